// file: pkg/vicif_pkg.sv
// Constants, carriers and state layout of the virtual CPU interface bank.
// Assumes the core presents one decoded system-register access per cycle.
package vicif_pkg;

  // ****************************************************************
  // Access encodings {op0, op1, crn, crm, op2}
  // ****************************************************************
  localparam logic [15:0] VICIF_ENC_AP0 = {2'h3, 3'h0, 4'hc, 4'h8, 3'h4};
  localparam logic [15:0] VICIF_ENC_AP1 = {2'h3, 3'h0, 4'hc, 4'h9, 3'h0};
  localparam logic [15:0] VICIF_ENC_BPR0 = {2'h3, 3'h0, 4'hc, 4'h8, 3'h3};
  localparam logic [15:0] VICIF_ENC_BPR1 = {2'h3, 3'h0, 4'hc, 4'hc, 3'h3};
  localparam logic [15:0] VICIF_ENC_CTLR = {2'h3, 3'h0, 4'hc, 4'hc, 3'h4};
  localparam logic [15:0] VICIF_ENC_EOI0 = {2'h3, 3'h0, 4'hc, 4'h8, 3'h1};
  localparam logic [15:0] VICIF_ENC_EOI1 = {2'h3, 3'h0, 4'hc, 4'hc, 3'h1};
  localparam logic [15:0] VICIF_ENC_DIR = {2'h3, 3'h0, 4'hc, 4'hb, 3'h1};
  localparam logic [15:0] VICIF_ENC_SRE3 = {2'h3, 3'h6, 4'hc, 4'hc, 3'h5};

  // ****************************************************************
  // Field positions and fixed values
  // ****************************************************************
  localparam int VICIF_SRE3_ENABLE_BIT = 3;
  localparam int VICIF_SRE3_IRQ_BYP_BIT = 2;
  localparam int VICIF_SRE3_FIQ_BYP_BIT = 1;
  localparam int VICIF_SRE3_SELECT_BIT = 0;
  localparam int VICIF_CTLR_A3V_BIT = 15;
  localparam int VICIF_CTLR_LOCAL_SYSERR_SUPPORT_BIT = 14;
  localparam int VICIF_CTLR_IDW_LSB = 11;
  localparam int VICIF_CTLR_PRIW_LSB = 8;
  localparam int VICIF_CTLR_EOI_BIT = 1;
  localparam int VICIF_CTLR_CBP_BIT = 0;
  localparam int VICIF_BP_LSB = 0;
  localparam int VICIF_BP_W = 3;
  localparam int VICIF_PRIO_LEVELS = 32;
  localparam int VICIF_PRIO_W = 5;
  localparam int VICIF_INTID_W = 16;

  localparam logic VICIF_A3V_VAL = 1'h1;
  localparam logic VICIF_LOCAL_SYSERR_SUPPORT_VAL = 1'h0;
  localparam logic [2:0] VICIF_IDW_VAL = 3'h0;
  localparam logic [2:0] VICIF_PRIW_VAL = 3'h4;
  localparam logic VICIF_ONE_VAL = 1'h1;
  localparam logic [2:0] VICIF_BP0_MIN = 3'h2;
  localparam logic [2:0] VICIF_BP1_S_MIN = 3'h2;
  localparam logic [2:0] VICIF_BP1_NS_MIN = 3'h3;
  localparam logic [2:0] VICIF_BP_MAX = 3'h7;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic valid;
    logic write;
    logic [1:0] op0;
    logic [2:0] op1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] op2;
    logic [31:0] wdata;
  } vicif_req_t;

  typedef struct packed {
    logic ack;
    logic undef;
    logic [31:0] rdata;
  } vicif_rsp_t;

  typedef struct packed {
    logic valid;
    logic group1;
    logic [4:0] prio;
  } vicif_act_t;

  typedef struct packed {
    vicif_rsp_t rsp;
    logic irq_byp_dis;
    logic fiq_byp_dis;
    logic [31:0] ap0;
    logic [31:0] ap1;
    logic [2:0] bpr0;
    logic [2:0] bpr1_s;
    logic [2:0] bpr1_ns;
    logic split_eoi;
    logic common_bp;
    logic [2:0] g0_bp;
    logic [2:0] g1_bp;
    logic deact_valid;
    logic [15:0] deact_intid;
  } vicif_state_t;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [31:0] VICIF_AP_RST = 32'h0;
  localparam logic [2:0] VICIF_BP0_RST = 3'h2;
  localparam logic [2:0] VICIF_BP1_S_RST = 3'h2;
  localparam logic [2:0] VICIF_BP1_NS_RST = 3'h3;
  localparam vicif_state_t VICIF_STATE_RST = '{
    rsp: '{ack: 1'h0, undef: 1'h0, rdata: 32'h0},
    irq_byp_dis: 1'h0, fiq_byp_dis: 1'h0,
    ap0: VICIF_AP_RST, ap1: VICIF_AP_RST,
    bpr0: VICIF_BP0_RST, bpr1_s: VICIF_BP1_S_RST,
    bpr1_ns: VICIF_BP1_NS_RST,
    split_eoi: 1'h0, common_bp: 1'h0,
    g0_bp: VICIF_BP0_RST, g1_bp: VICIF_BP1_NS_RST,
    deact_valid: 1'h0, deact_intid: 16'h0};

endpackage

// file: core/vicif_bp_calc.sv
// Binary point arithmetic: clamp a written value to the implemented
// minimum, and the plus-one saturated alias of a base value.
// Purely combinational; the caller registers the results.
`timescale 1ns/1ps
module vicif_bp_calc (
  input wire logic [2:0] i_wval,
  input wire logic [2:0] i_min,
  input wire logic [2:0] i_base,
  output logic [2:0] o_clamped,
  output logic [2:0] o_plus1_sat
);
  always_comb begin
    o_clamped = (i_wval < i_min) ? i_min : i_wval;
    if (i_base == vicif_pkg::VICIF_BP_MAX) begin
      o_plus1_sat = vicif_pkg::VICIF_BP_MAX;
    end else begin
      o_plus1_sat = i_base + 3'h1;
    end
  end
endmodule

// file: core/vicif_prio_drop.sv
// Finds the highest active priority (lowest set bit) of an
// active-priority bitmap and returns it as a one-hot clear mask.
// Combinational; an all-zero bitmap yields an all-zero mask.
`timescale 1ns/1ps
module vicif_prio_drop (
  input wire logic [31:0] i_bits,
  output logic [31:0] o_clear
);
  logic [32:0] below;
  assign below[0] = 1'b0;
  genvar n;
  generate
    for (n = 0; n < vicif_pkg::VICIF_PRIO_LEVELS; n++) begin : g_bit
      assign o_clear[n] = i_bits[n] & ~below[n];
      assign below[n + 1] = below[n] | i_bits[n];
    end
  endgenerate
endmodule

// file: core/vicif_regs.sv
// Register bank of the virtual CPU interface plus the EL3 register
// enable control, reached by system-register encoding.
// Assumes the core decodes privilege and traps before presenting an
// access; each access is one request cycle, answered one cycle later.
`timescale 1ns/1ps

module vicif_regs (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire vicif_pkg::vicif_req_t i_req,
  input wire vicif_pkg::vicif_act_t i_act,
  input wire logic i_secure,
  output vicif_pkg::vicif_rsp_t o_rsp,
  output logic o_irq_bypass_disable,
  output logic o_fiq_bypass_disable,
  output logic o_virt_split_eoi_mode,
  output logic o_virt_common_binary_point,
  output logic [2:0] o_g0_preempt_point,
  output logic [2:0] o_g1_preempt_point,
  output logic [31:0] o_g0_active,
  output logic [31:0] o_g1_active,
  output logic o_deact_valid,
  output logic [15:0] o_deact_intid
);

  // ****************************************************************
  // State
  // ****************************************************************
  vicif_pkg::vicif_state_t st_r;
  vicif_pkg::vicif_state_t st_nxt;

  logic [15:0] enc;
  logic is_wr;
  logic is_rd;
  logic [2:0] bp1_min;
  logic [2:0] bp1_cur;
  logic [2:0] bp0_clamped;
  logic [2:0] bp1_clamped;
  logic [2:0] bp0_plus1;
  logic [31:0] drop0_mask;
  logic [31:0] drop1_mask;
  logic [31:0] clr0;
  logic [31:0] clr1;
  logic [31:0] set0;
  logic [31:0] set1;
  logic [31:0] act_onehot;
  logic [31:0] ctlr_rd;
  logic [31:0] sre3_rd;
  logic [31:0] bpr0_rd;
  logic [31:0] bpr1_rd;

  assign enc = {i_req.op0, i_req.op1, i_req.crn, i_req.crm, i_req.op2};
  assign is_wr = i_req.valid & i_req.write;
  assign is_rd = i_req.valid & ~i_req.write;

  // Each security state keeps its own Group 1 instance
  assign bp1_min = i_secure ? vicif_pkg::VICIF_BP1_S_MIN
                            : vicif_pkg::VICIF_BP1_NS_MIN;
  assign bp1_cur = i_secure ? st_r.bpr1_s : st_r.bpr1_ns;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  vicif_bp_calc u_bp0 (
    .i_wval(i_req.wdata[2:0]),
    .i_min(vicif_pkg::VICIF_BP0_MIN),
    .i_base(st_r.bpr0),
    .o_clamped(bp0_clamped),
    .o_plus1_sat(bp0_plus1)
  );

  vicif_bp_calc u_bp1 (
    .i_wval(i_req.wdata[2:0]),
    .i_min(bp1_min),
    .i_base(bp1_cur),
    .o_clamped(bp1_clamped),
    .o_plus1_sat()
  );

  vicif_prio_drop u_drop0 (
    .i_bits(st_r.ap0),
    .o_clear(drop0_mask)
  );

  vicif_prio_drop u_drop1 (
    .i_bits(st_r.ap1),
    .o_clear(drop1_mask)
  );

  // ****************************************************************
  // Read images of the registers with fixed fields
  // ****************************************************************
  always_comb begin
    sre3_rd = 32'h0;
    sre3_rd[vicif_pkg::VICIF_SRE3_ENABLE_BIT] =
      vicif_pkg::VICIF_ONE_VAL;
    sre3_rd[vicif_pkg::VICIF_SRE3_IRQ_BYP_BIT] = st_r.irq_byp_dis;
    sre3_rd[vicif_pkg::VICIF_SRE3_FIQ_BYP_BIT] = st_r.fiq_byp_dis;
    sre3_rd[vicif_pkg::VICIF_SRE3_SELECT_BIT] =
      vicif_pkg::VICIF_ONE_VAL;
  end

  always_comb begin
    ctlr_rd = 32'h0;
    ctlr_rd[vicif_pkg::VICIF_CTLR_A3V_BIT] =
      vicif_pkg::VICIF_A3V_VAL;
    ctlr_rd[vicif_pkg::VICIF_CTLR_LOCAL_SYSERR_SUPPORT_BIT] =
      vicif_pkg::VICIF_LOCAL_SYSERR_SUPPORT_VAL;
    ctlr_rd[vicif_pkg::VICIF_CTLR_IDW_LSB +: 3] =
      vicif_pkg::VICIF_IDW_VAL;
    ctlr_rd[vicif_pkg::VICIF_CTLR_PRIW_LSB +: 3] =
      vicif_pkg::VICIF_PRIW_VAL;
    ctlr_rd[vicif_pkg::VICIF_CTLR_EOI_BIT] = st_r.split_eoi;
    ctlr_rd[vicif_pkg::VICIF_CTLR_CBP_BIT] = st_r.common_bp;
  end

  // ****************************************************************
  // Read images of the binary point registers
  // ****************************************************************
  // Clamping happens on write, so a stored point is always legal and
  // the read side only has to place it and zero the rest.
  always_comb begin
    bpr0_rd = 32'h0;
    bpr0_rd[vicif_pkg::VICIF_BP_LSB +: vicif_pkg::VICIF_BP_W] =
      st_r.bpr0;
  end

  // Under the common point the Group 1 view is derived, not stored, so
  // the banked values survive untouched for when the bit is cleared.
  always_comb begin
    bpr1_rd = 32'h0;
    if (st_r.common_bp) begin
      bpr1_rd[vicif_pkg::VICIF_BP_LSB +: vicif_pkg::VICIF_BP_W] =
        bp0_plus1;
    end else begin
      bpr1_rd[vicif_pkg::VICIF_BP_LSB +: vicif_pkg::VICIF_BP_W] =
        bp1_cur;
    end
  end

  // ****************************************************************
  // Activation from the acknowledge path
  // ****************************************************************
  // Bit n of a map stands for priority n*8, so the 5-bit level is the
  // bit index directly.
  // One comparator per level; a level outside the map cannot occur
  // because the priority field is exactly five bits wide.
  genvar lvl;
  generate
    for (lvl = 0; lvl < vicif_pkg::VICIF_PRIO_LEVELS; lvl++) begin : g_lvl
      assign act_onehot[lvl] = (i_act.prio == 5'(lvl));
    end
  endgenerate

  always_comb begin
    set0 = (i_act.valid & ~i_act.group1) ? act_onehot : 32'h0;
    set1 = (i_act.valid & i_act.group1) ? act_onehot : 32'h0;
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    clr0 = 32'h0;
    clr1 = 32'h0;
    st_nxt.rsp.ack = 1'b0;
    st_nxt.rsp.undef = 1'b0;
    st_nxt.rsp.rdata = 32'h0;
    st_nxt.deact_valid = 1'b0;
    if (i_req.valid) begin
      st_nxt.rsp.ack = 1'b1;
      case (enc)
        vicif_pkg::VICIF_ENC_SRE3: begin
          if (is_rd) begin
            st_nxt.rsp.rdata = sre3_rd;
          end else begin
            st_nxt.irq_byp_dis =
              i_req.wdata[vicif_pkg::VICIF_SRE3_IRQ_BYP_BIT];
            st_nxt.fiq_byp_dis =
              i_req.wdata[vicif_pkg::VICIF_SRE3_FIQ_BYP_BIT];
          end
        end
        vicif_pkg::VICIF_ENC_AP0: begin
          if (is_rd) begin
            st_nxt.rsp.rdata = st_r.ap0;
          end else begin
            st_nxt.ap0 = i_req.wdata;
          end
        end
        vicif_pkg::VICIF_ENC_AP1: begin
          if (is_rd) begin
            st_nxt.rsp.rdata = st_r.ap1;
          end else begin
            st_nxt.ap1 = i_req.wdata;
          end
        end
        vicif_pkg::VICIF_ENC_BPR0: begin
          if (is_rd) begin
            st_nxt.rsp.rdata = bpr0_rd;
          end else begin
            st_nxt.bpr0 = bp0_clamped;
          end
        end
        vicif_pkg::VICIF_ENC_BPR1: begin
          if (is_rd) begin
            st_nxt.rsp.rdata = bpr1_rd;
          end else if (!st_r.common_bp) begin
            if (i_secure) begin
              st_nxt.bpr1_s = bp1_clamped;
            end else begin
              st_nxt.bpr1_ns = bp1_clamped;
            end
          end
        end
        vicif_pkg::VICIF_ENC_CTLR: begin
          if (is_rd) begin
            st_nxt.rsp.rdata = ctlr_rd;
          end else begin
            // Feature fields are constants; only the two modes store
            st_nxt.split_eoi =
              i_req.wdata[vicif_pkg::VICIF_CTLR_EOI_BIT];
            st_nxt.common_bp =
              i_req.wdata[vicif_pkg::VICIF_CTLR_CBP_BIT];
          end
        end
        vicif_pkg::VICIF_ENC_EOI0: begin
          if (is_wr) begin
            clr0 = drop0_mask;
            if (!st_r.split_eoi) begin
              st_nxt.deact_valid = 1'b1;
              st_nxt.deact_intid = i_req.wdata[15:0];
            end
          end else begin
            st_nxt.rsp.undef = 1'b1;
          end
        end
        vicif_pkg::VICIF_ENC_EOI1: begin
          if (is_wr) begin
            clr1 = drop1_mask;
            if (!st_r.split_eoi) begin
              st_nxt.deact_valid = 1'b1;
              st_nxt.deact_intid = i_req.wdata[15:0];
            end
          end else begin
            st_nxt.rsp.undef = 1'b1;
          end
        end
        vicif_pkg::VICIF_ENC_DIR: begin
          // In combined mode this access has no defined effect; it is
          // acknowledged and dropped so software cannot double-deactivate
          if (is_wr) begin
            if (st_r.split_eoi) begin
              st_nxt.deact_valid = 1'b1;
              st_nxt.deact_intid = i_req.wdata[15:0];
            end
          end else begin
            st_nxt.rsp.undef = 1'b1;
          end
        end
        default: begin
          st_nxt.rsp.undef = 1'b1;
        end
      endcase
    end

    // A new activation wins over a same-cycle drop or software write
    st_nxt.ap0 = (st_nxt.ap0 & ~clr0) | set0;
    st_nxt.ap1 = (st_nxt.ap1 & ~clr1) | set1;

    // Effective preemption points follow the updated registers
    st_nxt.g0_bp = st_nxt.bpr0;
    if (st_nxt.common_bp) begin
      st_nxt.g1_bp = st_nxt.bpr0;
    end else if (i_secure) begin
      st_nxt.g1_bp = st_nxt.bpr1_s;
    end else begin
      st_nxt.g1_bp = st_nxt.bpr1_ns;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= vicif_pkg::VICIF_STATE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Outputs, all straight from the state register
  // ****************************************************************
  // Access answer: one cycle after the request, never stalled
  assign o_rsp = st_r.rsp;

  // Mode and bypass levels for the rest of the interface
  assign o_irq_bypass_disable = st_r.irq_byp_dis;
  assign o_fiq_bypass_disable = st_r.fiq_byp_dis;
  assign o_virt_split_eoi_mode = st_r.split_eoi;
  assign o_virt_common_binary_point = st_r.common_bp;

  // Effective preemption points change in the same cycle as a mode change,
  // being computed from the next state and kept on a flip-flop
  assign o_g0_preempt_point = st_r.g0_bp;
  assign o_g1_preempt_point = st_r.g1_bp;

  // Active maps and the deactivate request
  assign o_g0_active = st_r.ap0;
  assign o_g1_active = st_r.ap1;
  assign o_deact_valid = st_r.deact_valid;
  assign o_deact_intid = st_r.deact_intid;

endmodule

// file: verif/vicif_regs_sva.sv
// Concurrent checks on the ports of the virtual interface register bank.
// Assumes one clock domain and a bind from the bench top file.
`timescale 1ns/1ps
module vicif_regs_chk (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire vicif_pkg::vicif_req_t i_req,
  input wire vicif_pkg::vicif_act_t i_act,
  input wire vicif_pkg::vicif_rsp_t o_rsp,
  input wire logic o_irq_bypass_disable,
  input wire logic o_fiq_bypass_disable,
  input wire logic o_virt_split_eoi_mode,
  input wire logic o_virt_common_binary_point,
  input wire logic [2:0] o_g0_preempt_point,
  input wire logic [2:0] o_g1_preempt_point,
  input wire logic [31:0] o_g0_active,
  input wire logic o_deact_valid
);
  logic [15:0] enc;
  logic wr_sre;
  logic wr_eoi;
  logic rd_ctl;
  assign enc = {i_req.op0, i_req.op1, i_req.crn, i_req.crm, i_req.op2};
  assign wr_sre = i_req.valid && i_req.write &&
                  enc == vicif_pkg::VICIF_ENC_SRE3;
  assign wr_eoi = i_req.valid && i_req.write &&
                  (enc == vicif_pkg::VICIF_ENC_EOI0 ||
                   enc == vicif_pkg::VICIF_ENC_EOI1);
  assign rd_ctl = i_req.valid && !i_req.write &&
                  enc == vicif_pkg::VICIF_ENC_CTLR;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  ack_timing_a: assert property (i_req.valid |=> o_rsp.ack)
    else $error("access not answered in the next cycle");
  ack_cause_a: assert property (o_rsp.ack |-> $past(i_req.valid))
    else $error("answer without a request");
  ctl_fixed_a: assert property (
    rd_ctl |=> o_rsp.rdata[31:8] == 24'h84)
    else $error("control feature fields wrong");
  act_set_a: assert property (i_act.valid && !i_act.group1 |=>
    o_g0_active[$past(i_act.prio)])
    else $error("activation bit not set");
  irq_byp_a: assert property (wr_sre |=>
    o_irq_bypass_disable == $past(i_req.wdata[2]))
    else $error("irq bypass disable not taken");
  fiq_byp_a: assert property (wr_sre |=>
    o_fiq_bypass_disable == $past(i_req.wdata[1]))
    else $error("fiq bypass disable not taken");
  bp0_min_a: assert property (o_g0_preempt_point >= 3'h2)
    else $error("group0 point below minimum");
  common_bp_a: assert property (o_virt_common_binary_point &&
    $stable(o_virt_common_binary_point) && $stable(o_g0_preempt_point)
    |-> o_g1_preempt_point == o_g0_preempt_point)
    else $error("group1 point not following group0");
  eoi_deact_a: assert property (wr_eoi && !o_virt_split_eoi_mode
    |=> o_deact_valid)
    else $error("combined end of interrupt did not deactivate");
  eoi_split_a: assert property (wr_eoi && o_virt_split_eoi_mode
    |=> !o_deact_valid)
    else $error("split end of interrupt deactivated");
endmodule

// file: verif/vicif_regs_tb.sv
// Self-checking bench for the register bank, driving its access port.
// Assumes the package and design files are compiled before this one.
`timescale 1ns/1ps
module vicif_regs_tb;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  vicif_pkg::vicif_req_t req = '0;
  vicif_pkg::vicif_act_t act = '0;
  logic secure = 1'b0;
  vicif_pkg::vicif_rsp_t rsp;
  logic irq_dis, fiq_dis, split, common, dv, udv, dv_seen;
  logic [2:0] g0_pt, g1_pt;
  logic [31:0] g0_act, g1_act, rdv;
  logic [15:0] did, id_seen;
  int fails = 0;
  int checks_done = 0;

  always #12.5 i_sys_clk = ~i_sys_clk;

  vicif_regs dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_req(req),
    .i_act(act), .i_secure(secure), .o_rsp(rsp),
    .o_irq_bypass_disable(irq_dis), .o_fiq_bypass_disable(fiq_dis),
    .o_virt_split_eoi_mode(split), .o_virt_common_binary_point(common),
    .o_g0_preempt_point(g0_pt), .o_g1_preempt_point(g1_pt),
    .o_g0_active(g0_act), .o_g1_active(g1_act),
    .o_deact_valid(dv), .o_deact_intid(did));

  // ****************************************************************
  // Access tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One request cycle; the answer is taken in the cycle that follows
  task automatic acc(input logic w, input logic [15:0] e,
                     input logic [31:0] d);
    @(posedge i_sys_clk);
    #1;
    req.valid = 1'b1;
    req.write = w;
    {req.op0, req.op1, req.crn, req.crm, req.op2} = e;
    req.wdata = d;
    @(posedge i_sys_clk);
    #1;
    req.valid = 1'b0;
    chk({31'h0, rsp.ack}, 32'h1);
    rdv = rsp.rdata;
    udv = rsp.undef;
    dv_seen = dv;
    id_seen = did;
  endtask

  task automatic rd(input logic [15:0] e, input logic [31:0] exp);
    acc(1'b0, e, 32'h0);
    chk(rdv, exp);
    chk({31'h0, udv}, 32'h0);
  endtask

  task automatic pulse(input logic g1, input logic [4:0] p);
    @(posedge i_sys_clk);
    #1;
    act = '{valid: 1'b1, group1: g1, prio: p};
    @(posedge i_sys_clk);
    #1;
    act.valid = 1'b0;
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (2) @(posedge i_sys_clk);
    #1;
    i_rst_n = 1'b1;
    rd(vicif_pkg::VICIF_ENC_SRE3, 32'h9);
    rd(vicif_pkg::VICIF_ENC_CTLR, 32'h8400);
    rd(vicif_pkg::VICIF_ENC_AP0, 32'h0);
    rd(vicif_pkg::VICIF_ENC_AP1, 32'h0);
    rd(vicif_pkg::VICIF_ENC_BPR0, 32'h2);
    rd(vicif_pkg::VICIF_ENC_BPR1, 32'h3);
    acc(1'b1, vicif_pkg::VICIF_ENC_SRE3, 32'hffffffff);
    rd(vicif_pkg::VICIF_ENC_SRE3, 32'hf);
    chk({30'h0, irq_dis, fiq_dis}, 32'h3);
    acc(1'b1, vicif_pkg::VICIF_ENC_SRE3, 32'h4);
    rd(vicif_pkg::VICIF_ENC_SRE3, 32'hd);
    chk({30'h0, irq_dis, fiq_dis}, 32'h2);
    acc(1'b1, vicif_pkg::VICIF_ENC_BPR0, 32'h0);
    rd(vicif_pkg::VICIF_ENC_BPR0, 32'h2);
    acc(1'b1, vicif_pkg::VICIF_ENC_BPR0, 32'hfffffff5);
    rd(vicif_pkg::VICIF_ENC_BPR0, 32'h5);
    acc(1'b1, vicif_pkg::VICIF_ENC_BPR1, 32'h1);
    rd(vicif_pkg::VICIF_ENC_BPR1, 32'h3);
    secure = 1'b1;
    acc(1'b1, vicif_pkg::VICIF_ENC_BPR1, 32'h0);
    rd(vicif_pkg::VICIF_ENC_BPR1, 32'h2);
    acc(1'b1, vicif_pkg::VICIF_ENC_BPR1, 32'h4);
    rd(vicif_pkg::VICIF_ENC_BPR1, 32'h4);
    secure = 1'b0;
    rd(vicif_pkg::VICIF_ENC_BPR1, 32'h3);
    pulse(1'b0, 5'h1f);
    chk(g0_act, 32'h80000000);
    pulse(1'b0, 5'h2);
    rd(vicif_pkg::VICIF_ENC_AP0, 32'h80000004);
    acc(1'b1, vicif_pkg::VICIF_ENC_EOI0, 32'h1234);
    chk({15'h0, dv_seen, id_seen}, 32'h11234);
    chk(g0_act, 32'h80000000);
    acc(1'b1, vicif_pkg::VICIF_ENC_CTLR, 32'hffffffff);
    rd(vicif_pkg::VICIF_ENC_CTLR, 32'h8403);
    chk({30'h0, split, common}, 32'h3);
    acc(1'b1, vicif_pkg::VICIF_ENC_AP1, 32'ha5a50000);
    rd(vicif_pkg::VICIF_ENC_AP1, 32'ha5a50000);
    pulse(1'b1, 5'h0);
    chk(g1_act, 32'ha5a50001);
    acc(1'b1, vicif_pkg::VICIF_ENC_EOI1, 32'h55);
    chk({31'h0, dv_seen}, 32'h0);
    chk(g1_act, 32'ha5a50000);
    acc(1'b1, vicif_pkg::VICIF_ENC_DIR, 32'h66);
    chk({15'h0, dv_seen, id_seen}, 32'h10066);
    // Common point: group1 reads group0 plus one, saturating
    rd(vicif_pkg::VICIF_ENC_BPR1, 32'h6);
    acc(1'b1, vicif_pkg::VICIF_ENC_BPR1, 32'h2);
    rd(vicif_pkg::VICIF_ENC_BPR1, 32'h6);
    chk({29'h0, g1_pt}, 32'h5);
    acc(1'b1, vicif_pkg::VICIF_ENC_BPR0, 32'h7);
    rd(vicif_pkg::VICIF_ENC_BPR1, 32'h7);
    chk({29'h0, g0_pt}, 32'h7);
    acc(1'b1, vicif_pkg::VICIF_ENC_CTLR, 32'h0);
    chk({30'h0, split, common}, 32'h0);
    rd(vicif_pkg::VICIF_ENC_BPR1, 32'h3);
    chk({29'h0, g1_pt}, 32'h3);
    acc(1'b0, {2'h3, 3'h0, 4'hc, 4'hd, 3'h7}, 32'h0);
    chk({udv, rdv[30:0]}, 32'h80000000);
    acc(1'b0, vicif_pkg::VICIF_ENC_EOI0, 32'h0);
    chk({31'h0, udv}, 32'h1);
    complete_run();
  end

  initial begin
    repeat (2000) @(posedge i_sys_clk);
    fails++;
    complete_run();
  end
endmodule

bind vicif_regs vicif_regs_chk u_chk (.i_sys_clk(i_sys_clk),
  .i_rst_n(i_rst_n), .i_req(i_req), .i_act(i_act), .o_rsp(o_rsp),
  .o_irq_bypass_disable(o_irq_bypass_disable),
  .o_fiq_bypass_disable(o_fiq_bypass_disable),
  .o_virt_split_eoi_mode(o_virt_split_eoi_mode),
  .o_virt_common_binary_point(o_virt_common_binary_point),
  .o_g0_preempt_point(o_g0_preempt_point),
  .o_g1_preempt_point(o_g1_preempt_point),
  .o_g0_active(o_g0_active), .o_deact_valid(o_deact_valid));
